/* File: rtl/page_seq_params.svh */
`ifndef PAGE_SEQ_PARAMS_SVH
`define PAGE_SEQ_PARAMS_SVH
`define PAGE_W         7
`define PIN_W          3
`define WD_W           12
`define ADDR_W         24
`define FACTORY_PAGE   7'h00
`define APP_PAGE_LOCAL 7'h01
`define FACTORY_ADDR   24'h00_0000
`define ADDR_PAGE_LSB  16
`define OSC_HZ         10_000_000
`define CLK_HZ         100_000_000
`define OSC_DIV        (`CLK_HZ / `OSC_HZ)
`define WD_SHIFT       5
`define CAUSE_W        4
`define CAUSE_STATUS   0
`define CAUSE_CRC      1
`define CAUSE_WD       2
`define CAUSE_RESET    3
`endif

/* File: rtl/page_seq_pkg.sv */
package page_seq_pkg;
  typedef enum logic [1:0] {
    SCHEME_FAST_PARALLEL,
    SCHEME_PASSIVE_SERIAL,
    SCHEME_PARALLEL_ASYNC,
    SCHEME_ACTIVE_SERIAL
  } scheme_t;
  typedef enum {
    ST_POWER_UP,
    ST_LOAD,
    ST_USER,
    ST_RECONFIG
  } seq_state_t;
endpackage

/* File: rtl/osc_tick_if.sv */
`timescale 1ns/1ps
interface osc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface

/* File: rtl/osc_tick_gen.sv */
`timescale 1ns/1ps
`include "page_seq_params.svh"
module osc_tick_gen (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  osc_tick_if.src   tick_o
);
  localparam int CNT_W = $clog2(`OSC_DIV);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  always_comb begin
    tick_next = (cnt_reg == CNT_W'(`OSC_DIV - 1));
    cnt_next  = tick_next ? '0 : cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o.tick = tick_reg;
endmodule

/* File: rtl/remote_upgrade_page_sequencer.sv */
`timescale 1ns/1ps
`include "page_seq_params.svh"
// Function
// - Remote mode powers up on factory page zero, pins and register zero.
// - Factory image fetched from serial memory start address zero.
// - Record reconfiguration cause: status low, CRC, watchdog, config reset.
// - Watchdog held disabled while factory configuration is loaded.
// - Remote mode reloads factory page zero after any recorded cause.
// - Active serial scheme: device reads memory at current page address.
// - Local mode drives page one on power up or config reset.
// - Local mode retries factory page zero on CRC or status-low error.
// - Local mode external config reset reloads application page one.
// - Active serial scheme runs remote mode only, never local mode.
// - Local mode allows status reads, blocks every control write.
// - Local mode keeps the watchdog disabled at all times.
// - Serial start address is page register at bits 22..16, rest zero.
// - Control and watchdog advance on the 10 MHz oscillator tick; status cause records at once.
module remote_upgrade_page_sequencer (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Mode and scheme straps
  input  wire logic                     update_mode_select_i,
  input  wire page_seq_pkg::scheme_t    scheme_i,
  // Configuration pins and events
  input  wire logic                     config_status_n_i,
  input  wire logic                     config_reset_n_i,
  input  wire logic                     logic_config_reset_i,
  input  wire logic                     crc_error_i,
  input  wire logic                     load_done_i,
  // Control register write port from the factory design
  input  wire logic                     ctrl_wr_i,
  input  wire logic [`PAGE_W-1:0]       ctrl_page_i,
  input  wire logic                     ctrl_wd_en_i,
  input  wire logic [`WD_W-1:0]         ctrl_wd_timeout_i,
  input  wire logic                     reconfig_req_i,
  input  wire logic                     wd_restart_i,
  // Page selection outputs
  output logic [`PIN_W-1:0]             page_index_o,
  output logic [`PAGE_W-1:0]            page_reg_o,
  output logic [`ADDR_W-1:0]            flash_addr_o,
  output logic                          flash_read_o,
  output logic                          config_start_o,
  // Status
  output logic                          remote_mode_o,
  output logic                          app_not_factory_o,
  output logic                          user_mode_o,
  output logic                          wd_enabled_o,
  output logic [`CAUSE_W-1:0]           status_cause_o,
  output logic                          ctrl_wr_blocked_o
);
  osc_tick_if osc ();
  osc_tick_gen u_osc (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (osc)
  );

  // Three-stage synchronisers for pins; first stage feeds only the second
  logic [2:0] sts_sync_reg;
  logic [2:0] rst_sync_reg;
  logic [2:0] mode_sync_reg;
  logic       sts_low_reg;
  logic       cfg_rst_low_reg;
  logic       sts_low_next;
  logic       cfg_rst_low_next;
  // Counts shift-ins so the strap is never taken from reset contents
  logic [1:0] fill_reg;
  logic [1:0] fill_next;

  always_comb begin
    fill_next        = (fill_reg == 2'h3) ? fill_reg : fill_reg + 2'h1;
    sts_low_next     = sts_low_reg;
    cfg_rst_low_next = cfg_rst_low_reg;
    if (sts_sync_reg[1] == sts_sync_reg[2]) begin
      sts_low_next = !sts_sync_reg[2];
    end
    if (rst_sync_reg[1] == rst_sync_reg[2]) begin
      cfg_rst_low_next = !rst_sync_reg[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sts_sync_reg    <= 3'b111;
      rst_sync_reg    <= 3'b111;
      mode_sync_reg   <= 3'b000;
      fill_reg        <= 2'h0;
      sts_low_reg     <= 1'b0;
      cfg_rst_low_reg <= 1'b0;
    end else begin
      sts_sync_reg    <= {sts_sync_reg[1:0], config_status_n_i};
      rst_sync_reg    <= {rst_sync_reg[1:0], config_reset_n_i};
      mode_sync_reg   <= {mode_sync_reg[1:0], update_mode_select_i};
      fill_reg        <= fill_next;
      sts_low_reg     <= sts_low_next;
      cfg_rst_low_reg <= cfg_rst_low_next;
    end
  end

  function automatic logic [`ADDR_W-1:0] start_addr(input logic [`PAGE_W-1:0] pg);
    start_addr = `FACTORY_ADDR | (`ADDR_W'(pg) << `ADDR_PAGE_LSB);
  endfunction

  page_seq_pkg::seq_state_t state_reg;
  page_seq_pkg::seq_state_t state_next;
  logic                        remote_reg,   remote_next;
  logic                        anf_reg,      anf_next;
  logic [`PAGE_W-1:0]          page_reg,     page_next;
  logic                        wd_en_reg,    wd_en_next;
  logic [`WD_W-1:0]            wd_to_reg,    wd_to_next;
  logic [`WD_W+`WD_SHIFT-1:0]  wd_cnt_reg,   wd_cnt_next;
  logic [`CAUSE_W-1:0]         cause_reg,    cause_next;
  logic                        pend_wr_reg,  pend_wr_next;
  logic [`PAGE_W-1:0]          pend_pg_reg,  pend_pg_next;
  logic                        pend_wd_reg,  pend_wd_next;
  logic [`WD_W-1:0]            pend_to_reg,  pend_to_next;
  logic                        start_next;
  logic                        blocked_next;
  logic                        wd_timeout;
  logic                        err_evt;
  logic                        rst_evt;

  assign err_evt    = crc_error_i || sts_low_reg;
  assign rst_evt    = cfg_rst_low_reg || logic_config_reset_i;
  assign wd_timeout = wd_en_reg && (wd_cnt_reg == '0);

  always_comb begin
    state_next   = state_reg;
    remote_next  = remote_reg;
    anf_next     = anf_reg;
    page_next    = page_reg;
    wd_en_next   = wd_en_reg;
    wd_to_next   = wd_to_reg;
    wd_cnt_next  = wd_cnt_reg;
    cause_next   = cause_reg;
    pend_wr_next = pend_wr_reg;
    pend_pg_next = pend_pg_reg;
    pend_wd_next = pend_wd_reg;
    pend_to_next = pend_to_reg;
    start_next   = 1'b0;
    blocked_next = 1'b0;
    // Factory design writes land on the fast clock; committed on the osc tick
    if (ctrl_wr_i) begin
      if (remote_reg && !anf_reg) begin
        pend_wr_next = 1'b1;
        pend_pg_next = ctrl_page_i;
        pend_wd_next = ctrl_wd_en_i;
        pend_to_next = ctrl_wd_timeout_i;
      end else begin
        blocked_next = 1'b1;
      end
    end
    case (state_reg)
      page_seq_pkg::ST_POWER_UP: begin
        // Mode taken once the sampled strap has settled; never revisited
        if (fill_reg == 2'h3 && mode_sync_reg[1] == mode_sync_reg[2]) begin
          remote_next = mode_sync_reg[2] || (scheme_i == page_seq_pkg::SCHEME_ACTIVE_SERIAL);
          anf_next    = !remote_next;
          page_next   = remote_next ? `FACTORY_PAGE : `APP_PAGE_LOCAL;
          wd_en_next  = 1'b0;
          state_next  = page_seq_pkg::ST_LOAD;
          start_next  = 1'b1;
        end
      end
      page_seq_pkg::ST_LOAD: begin
        if (err_evt) begin
          cause_next = `CAUSE_W'(1 << (sts_low_reg ? `CAUSE_STATUS : `CAUSE_CRC));
          state_next = page_seq_pkg::ST_RECONFIG;
          pend_wr_next = 1'b0;
        end else if (load_done_i) begin
          state_next  = page_seq_pkg::ST_USER;
          wd_cnt_next = {wd_to_reg, {`WD_SHIFT{1'b1}}};
        end
      end
      page_seq_pkg::ST_USER: begin
        if (osc.tick && wd_en_reg && !wd_timeout) begin
          wd_cnt_next = wd_cnt_reg - 1'b1;
        end
        if (wd_restart_i) begin
          wd_cnt_next = {wd_to_reg, {`WD_SHIFT{1'b1}}};
        end
        if (rst_evt) begin
          cause_next = `CAUSE_W'(1 << `CAUSE_RESET);
          state_next = page_seq_pkg::ST_RECONFIG;
          pend_wr_next = 1'b0;
        end else if (err_evt) begin
          cause_next = `CAUSE_W'(1 << (sts_low_reg ? `CAUSE_STATUS : `CAUSE_CRC));
          state_next = page_seq_pkg::ST_RECONFIG;
          pend_wr_next = 1'b0;
        end else if (wd_timeout) begin
          cause_next = `CAUSE_W'(1 << `CAUSE_WD);
          state_next = page_seq_pkg::ST_RECONFIG;
          pend_wr_next = 1'b0;
        end else if (reconfig_req_i && remote_reg && !anf_reg && (pend_wr_reg || pend_wr_next)) begin
          // Factory-requested jump to an application page
          state_next = page_seq_pkg::ST_RECONFIG;
        end
      end
      page_seq_pkg::ST_RECONFIG: begin
        // Control commits on the oscillator tick; status cause was recorded on entry
        if (osc.tick) begin
          state_next = page_seq_pkg::ST_LOAD;
          start_next = 1'b1;
          // Status keeps its last cause, so only a surviving write marks a factory request
          if (!pend_wr_reg) begin
            if (!remote_reg && cause_reg[`CAUSE_RESET]) begin
              page_next = `APP_PAGE_LOCAL;
              anf_next  = 1'b1;
            end else begin
              page_next = `FACTORY_PAGE;
              anf_next  = 1'b0;
            end
            wd_en_next = 1'b0;
          end else begin
            page_next    = pend_pg_reg;
            anf_next     = 1'b1;
            wd_en_next   = pend_wd_reg;
            wd_to_next   = pend_to_reg;
            pend_wr_next = 1'b0;
          end
        end
      end
      default: state_next = page_seq_pkg::ST_POWER_UP;
    endcase
    if (!remote_reg || !anf_next) begin
      wd_en_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg         <= page_seq_pkg::ST_POWER_UP;
      remote_reg        <= 1'b1;
      anf_reg           <= 1'b0;
      page_reg          <= `FACTORY_PAGE;
      wd_en_reg         <= 1'b0;
      wd_to_reg         <= '0;
      wd_cnt_reg        <= '0;
      cause_reg         <= '0;
      pend_wr_reg       <= 1'b0;
      pend_pg_reg       <= '0;
      pend_wd_reg       <= 1'b0;
      pend_to_reg       <= '0;
      config_start_o    <= 1'b0;
      ctrl_wr_blocked_o <= 1'b0;
      page_index_o      <= '0;
      page_reg_o        <= '0;
      flash_addr_o      <= `FACTORY_ADDR;
      flash_read_o      <= 1'b0;
      remote_mode_o     <= 1'b1;
      app_not_factory_o <= 1'b0;
      user_mode_o       <= 1'b0;
      wd_enabled_o      <= 1'b0;
      status_cause_o    <= '0;
    end else begin
      state_reg         <= state_next;
      remote_reg        <= remote_next;
      anf_reg           <= anf_next;
      page_reg          <= page_next;
      wd_en_reg         <= wd_en_next;
      wd_to_reg         <= wd_to_next;
      wd_cnt_reg        <= wd_cnt_next;
      cause_reg         <= cause_next;
      pend_wr_reg       <= pend_wr_next;
      pend_pg_reg       <= pend_pg_next;
      pend_wd_reg       <= pend_wd_next;
      pend_to_reg       <= pend_to_next;
      config_start_o    <= start_next;
      ctrl_wr_blocked_o <= blocked_next;
      page_index_o      <= page_next[`PIN_W-1:0];
      page_reg_o        <= page_next;
      flash_addr_o      <= start_addr(page_next);
      flash_read_o      <= (scheme_i == page_seq_pkg::SCHEME_ACTIVE_SERIAL)
                           && (state_next == page_seq_pkg::ST_LOAD);
      remote_mode_o     <= remote_next;
      app_not_factory_o <= anf_next;
      user_mode_o       <= (state_next == page_seq_pkg::ST_USER);
      wd_enabled_o      <= wd_en_next;
      status_cause_o    <= cause_next;
    end
  end
endmodule

/* File: verif/page_seq_props.sv */
`timescale 1ns/1ps
`include "page_seq_params.svh"
module page_seq_props (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Inputs watched
  input  wire page_seq_pkg::scheme_t    scheme_i,
  input  wire logic                     crc_error_i,
  input  wire logic                     ctrl_wr_i,
  // Outputs watched
  input  wire logic [`PIN_W-1:0]        page_index_o,
  input  wire logic [`PAGE_W-1:0]       page_reg_o,
  input  wire logic [`ADDR_W-1:0]       flash_addr_o,
  input  wire logic                     flash_read_o,
  input  wire logic                     config_start_o,
  input  wire logic                     remote_mode_o,
  input  wire logic                     app_not_factory_o,
  input  wire logic                     user_mode_o,
  input  wire logic                     wd_enabled_o,
  input  wire logic [`CAUSE_W-1:0]      status_cause_o,
  input  wire logic                     ctrl_wr_blocked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  factory_wd_off_a: assert property (!app_not_factory_o |-> !wd_enabled_o)
    else $error("watchdog enabled in factory image");
  local_wd_off_a: assert property (!remote_mode_o |-> !wd_enabled_o)
    else $error("watchdog enabled in local mode");
  local_wr_block_a: assert property (ctrl_wr_i && !remote_mode_o |=> ctrl_wr_blocked_o)
    else $error("local mode control write not refused");
  crc_reload_a: assert property (crc_error_i && user_mode_o && remote_mode_o
    |=> status_cause_o == 4'h2 ##[0:11] (config_start_o && page_reg_o == 7'h00))
    else $error("crc error not recorded or factory not reloaded");
  local_err_page_a: assert property (crc_error_i && !remote_mode_o
    |=> ##[0:11] (config_start_o && page_reg_o == 7'h00))
    else $error("local error did not retry factory page");
  local_app_page_a: assert property (config_start_o && !remote_mode_o && app_not_factory_o
    |-> page_reg_o == 7'h01)
    else $error("local application load not on page one");
  factory_page_zero_a: assert property (config_start_o && !app_not_factory_o |-> page_reg_o == 7'h00)
    else $error("factory load not on page zero");
  page_pins_a: assert property (page_index_o == page_reg_o[2:0])
    else $error("page pins differ from page register");
  flash_addr_a: assert property (flash_addr_o == {1'b0, page_reg_o, 16'h0000})
    else $error("serial start address malformed");
  serial_remote_a: assert property (scheme_i == page_seq_pkg::SCHEME_ACTIVE_SERIAL && user_mode_o
    |-> remote_mode_o)
    else $error("local mode with active serial scheme");
  mode_hold_a: assert property (user_mode_o |-> $stable(remote_mode_o))
    else $error("update mode changed after power up");
  flash_read_as_a: assert property (flash_read_o |-> scheme_i == page_seq_pkg::SCHEME_ACTIVE_SERIAL)
    else $error("serial read outside active serial scheme");
  cover property (config_start_o && app_not_factory_o);
  cover property (ctrl_wr_blocked_o);
  cover property (status_cause_o == 4'h4 && config_start_o);
endmodule

/* File: verif/config_host_model.sv */
`timescale 1ns/1ps
`include "page_seq_params.svh"
module config_host_model (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Device side
  input  wire logic                     config_start_i,
  input  wire logic [`PIN_W-1:0]        page_index_i,
  input  wire logic                     flash_read_i,
  input  wire logic [`ADDR_W-1:0]       flash_addr_i,
  output logic                          load_done_o,
  output logic                          crc_error_o,
  // Bench control
  input  wire logic                     slow_i,
  input  wire logic                     fail_i,
  output logic [`ADDR_W-1:0]            seen_addr_o
);
  logic [5:0] wait_reg;
  logic       busy_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg    <= 1'b0;
      wait_reg    <= 6'h00;
      load_done_o <= 1'b0;
      crc_error_o <= 1'b0;
      // Poison value so a load that never reports its page cannot pass as page zero
      seen_addr_o <= 24'hFF_FFFF;
    end else begin
      load_done_o <= 1'b0;
      crc_error_o <= 1'b0;
      if (config_start_i) begin
        busy_reg    <= 1'b1;
        wait_reg    <= slow_i ? 6'h28 : 6'h03;
        seen_addr_o <= {21'h00_0000, page_index_i};
      end else if (busy_reg) begin
        // Serial memory path: the device presents the address it reads from
        if (flash_read_i)
          seen_addr_o <= flash_addr_i;
        wait_reg <= wait_reg - 6'h01;
        if (wait_reg == 6'h00) begin
          busy_reg    <= 1'b0;
          load_done_o <= !fail_i;
          crc_error_o <= fail_i;
        end
      end
    end
  end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "page_seq_params.svh"
bind remote_upgrade_page_sequencer page_seq_props page_seq_props_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .scheme_i(scheme_i), .crc_error_i(crc_error_i), .ctrl_wr_i(ctrl_wr_i),
  .page_index_o(page_index_o), .page_reg_o(page_reg_o), .flash_addr_o(flash_addr_o),
  .flash_read_o(flash_read_o), .config_start_o(config_start_o), .remote_mode_o(remote_mode_o),
  .app_not_factory_o(app_not_factory_o), .user_mode_o(user_mode_o), .wd_enabled_o(wd_enabled_o),
  .status_cause_o(status_cause_o), .ctrl_wr_blocked_o(ctrl_wr_blocked_o));
module tb;
  logic clk_i = 1'b0, rst_b = 1'b0, mode_sel = 1'b1, status_n = 1'b1, reset_n = 1'b1, logic_rst = 1'b0;
  logic tb_crc = 1'b0, host_crc, load_done, ctrl_wr = 1'b0, wd_en = 1'b0, reconfig = 1'b0, wd_restart = 1'b0;
  logic slow = 1'b0, fail = 1'b0, start, flash_rd, remote, app, user, wd_on, blocked;
  logic [6:0] ctrl_page = 7'h00, page_reg;
  logic [11:0] wd_to = 12'h000;
  logic [2:0] page_idx;
  logic [23:0] flash_addr, seen;
  logic [3:0] cause;
  page_seq_pkg::scheme_t scheme = page_seq_pkg::SCHEME_FAST_PARALLEL;
  int err_total = 0;
  int comparisons = 0;
  always #5 clk_i = ~clk_i;
  remote_upgrade_page_sequencer remote_upgrade_page_sequencer_inst (.clk_i(clk_i), .rst_b_i(rst_b),
    .update_mode_select_i(mode_sel), .scheme_i(scheme), .config_status_n_i(status_n), .config_reset_n_i(reset_n),
    .logic_config_reset_i(logic_rst), .crc_error_i(host_crc | tb_crc), .load_done_i(load_done),
    .ctrl_wr_i(ctrl_wr), .ctrl_page_i(ctrl_page), .ctrl_wd_en_i(wd_en), .ctrl_wd_timeout_i(wd_to),
    .reconfig_req_i(reconfig), .wd_restart_i(wd_restart), .page_index_o(page_idx), .page_reg_o(page_reg),
    .flash_addr_o(flash_addr), .flash_read_o(flash_rd), .config_start_o(start), .remote_mode_o(remote),
    .app_not_factory_o(app), .user_mode_o(user), .wd_enabled_o(wd_on), .status_cause_o(cause),
    .ctrl_wr_blocked_o(blocked));
  config_host_model config_host_model_inst (.clk_i(clk_i), .rst_b_i(rst_b), .config_start_i(start),
    .page_index_i(page_idx), .flash_read_i(flash_rd), .flash_addr_i(flash_addr), .load_done_o(load_done),
    .crc_error_o(host_crc), .slow_i(slow), .fail_i(fail), .seen_addr_o(seen));
  task automatic results();
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic mode, input page_seq_pkg::scheme_t sch);
    @(posedge clk_i);
    rst_b <= 1'b0;
    mode_sel <= mode;
    scheme <= sch;
    repeat (2) @(posedge clk_i);
    rst_b <= 1'b1;
    @(negedge clk_i);
  endtask
  // Start pulse trails the cause update by at least one cycle, so it is looked for before the first wait
  task automatic wait_user();
    int n;
    n = 0;
    while (start !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    while (user !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      results();
    end
  endtask
  task automatic wait_cause(input logic [3:0] exp);
    int n;
    n = 0;
    while (cause !== exp && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    chk({20'h0_0000, cause}, {20'h0_0000, exp});
    if (n >= 2000)
      results();
  endtask
  task automatic wr_ctrl(input logic [6:0] pg, input logic en, input logic [11:0] to);
    @(posedge clk_i);
    ctrl_wr <= 1'b1;
    ctrl_page <= pg;
    wd_en <= en;
    wd_to <= to;
    reconfig <= 1'b1;
    @(posedge clk_i);
    ctrl_wr <= 1'b0;
    reconfig <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic pulse_rst_logic();
    @(posedge clk_i);
    logic_rst <= 1'b1;
    @(posedge clk_i);
    logic_rst <= 1'b0;
    @(negedge clk_i);
  endtask
  initial begin
    do_reset(1'b1, page_seq_pkg::SCHEME_FAST_PARALLEL);
    wait_user();
    chk({21'h00_0000, page_idx}, 24'h00_0000);
    chk({23'h00_0000, wd_on}, 24'h00_0000);
    wr_ctrl(7'h05, 1'b1, 12'h001);
    wait_user();
    chk(seen, 24'h00_0005);
    chk({22'h00_0000, app, wd_on}, 24'h00_0003);
    wait_cause(4'h4);
    wait_user();
    chk({17'h0_0000, page_reg}, 24'h00_0000);
    slow <= 1'b1;
    wr_ctrl(7'h03, 1'b1, 12'h001);
    wait_user();
    // Restart held 12 clocks at a time; the watchdog reloads on every clock it is high, tick or not
    repeat (60) begin
      @(posedge clk_i);
      wd_restart <= 1'b1;
      repeat (12) @(posedge clk_i);
      wd_restart <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    @(negedge clk_i);
    chk({17'h0_0000, page_reg}, 24'h00_0003);
    @(posedge clk_i);
    tb_crc <= 1'b1;
    @(posedge clk_i);
    tb_crc <= 1'b0;
    wait_cause(4'h2);
    wait_user();
    chk({17'h0_0000, page_reg}, 24'h00_0000);
    @(posedge clk_i);
    status_n <= 1'b0;
    wait_cause(4'h1);
    @(posedge clk_i);
    status_n <= 1'b1;
    wait_user();
    @(posedge clk_i);
    reset_n <= 1'b0;
    wait_cause(4'h8);
    @(posedge clk_i);
    reset_n <= 1'b1;
    wait_user();
    chk({17'h0_0000, page_reg}, 24'h00_0000);
    slow <= 1'b0;
    do_reset(1'b0, page_seq_pkg::SCHEME_PASSIVE_SERIAL);
    wait_user();
    chk({21'h00_0000, page_idx}, 24'h00_0001);
    chk({22'h00_0000, remote, wd_on}, 24'h00_0000);
    wr_ctrl(7'h05, 1'b1, 12'h001);
    chk({23'h00_0000, blocked}, 24'h00_0001);
    repeat (20) @(negedge clk_i);
    chk({17'h0_0000, page_reg}, 24'h00_0001);
    fail <= 1'b1;
    pulse_rst_logic();
    wait_cause(4'h8);
    wait_cause(4'h2);
    fail <= 1'b0;
    wait_user();
    chk({17'h0_0000, page_reg}, 24'h00_0000);
    pulse_rst_logic();
    wait_cause(4'h8);
    wait_user();
    chk({17'h0_0000, page_reg}, 24'h00_0001);
    do_reset(1'b1, page_seq_pkg::SCHEME_PARALLEL_ASYNC);
    wait_user();
    chk(seen, 24'h00_0000);
    do_reset(1'b0, page_seq_pkg::SCHEME_ACTIVE_SERIAL);
    wait_user();
    chk({23'h00_0000, remote}, 24'h00_0001);
    chk(seen, 24'h00_0000);
    wr_ctrl(7'h45, 1'b0, 12'h000);
    wait_user();
    chk(flash_addr, 24'h45_0000);
    chk(seen, 24'h45_0000);
    results();
  end
endmodule
